/* File: rtl/sldio_port.v */
// six-line digital i/o port with avalon-mm register slave
// assumes one 100 mhz clock, synchronous active-high reset
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "sldio_consts.vh"
module sldio_port #(
    parameter NLINES = 6
) (
    // clock and reset
    input  wire                 ref_clk,
    input  wire                 reset,
    // avalon-mm slave
    input  wire [3:0]           avs_address,
    input  wire                 avs_read,
    input  wire                 avs_write,
    input  wire [31:0]          avs_writedata,
    input  wire [3:0]           avs_byteenable,
    output reg  [31:0]          avs_readdata,
    output wire                 avs_waitrequest,
    // instrument events
    input  wire                 meas_settled,
    input  wire                 overvoltage_trip,
    input  wire                 overcurrent_trip,
    input  wire                 overtemp_trip,
    input  wire                 sense_reversed,
    output reg                  trigger_pulse_r,
    // digital lines
    input  wire [NLINES-1:0]    line_in,
    output reg  [NLINES-1:0]    line_out_r,
    output reg  [NLINES-1:0]    line_oe_r,
    // interrupt
    output wire                 irq
);

// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
reg  [2*NLINES-1:0]      func_r;
reg  [1:0]               edge_sel_r;
reg  [7:0]               rddata_r;
reg  [`SLDIO_ST_W-1:0]   status_r;
reg  [`SLDIO_ST_W-1:0]   mask_r;
reg  [15:0]              errcode_r;
reg                      ack_r;
reg                      lvl1_prev_r;
reg  [`SLDIO_CNT_W-1:0]  done_cnt_r;
reg  [`SLDIO_CNT_W-1:0]  prot_cnt_r;
reg                      settled_prev_r;
reg                      prot_prev_r;
reg  [`SLDIO_ST_W-1:0]   status_nxt;
reg  [`SLDIO_ST_W-1:0]   events;
reg  [31:0]              rd_mux;
reg  [7:0]               rddata_nxt;
reg                      rd_err;
reg  [NLINES-1:0]        out_nxt;
reg  [NLINES-1:0]        oe_nxt;
wire [NLINES-1:0]        level;
wire                     any_protection_trip;
wire                     fire_done;
wire                     fire_prot;
wire                     trig_hit;
wire                     wr_acc;
wire                     rd_load;
wire [`SLDIO_CNT_W-1:0]  pulse_load;
integer                  i;

localparam [`SLDIO_CNT_W-1:0] PULSE_CYC = `SLDIO_PULSE_CYC;

assign pulse_load = PULSE_CYC;

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [1:0] fn_of;
    input [2*NLINES-1:0] f;
    input integer        n;
    begin
        fn_of = f[2*n +: 2];
    end
endfunction

function [`SLDIO_CNT_W-1:0] cnt_step;
    input                     fire;
    input [`SLDIO_CNT_W-1:0]  cnt;
    input [`SLDIO_CNT_W-1:0]  load;
    begin
        if (fire) begin
            cnt_step = load;
        end else if (cnt != {`SLDIO_CNT_W{1'b0}}) begin
            cnt_step = cnt - 1'b1;
        end else begin
            cnt_step = cnt;
        end
    end
endfunction

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < NLINES; g = g + 1) begin : g_sync
        sldio_sync #(
            .RST_VAL (1'b0)
        ) u_sync (
            .ref_clk (ref_clk),
            .reset   (reset),
            .pin_in  (line_in[g]),
            .level_r (level[g])
        );
    end
endgenerate

// ----------------------------------------------------------------
// bus handshake
// ----------------------------------------------------------------
assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
assign wr_acc          = avs_write & ack_r;
assign rd_load         = avs_read & ~ack_r;

// ----------------------------------------------------------------
// automatic functions
// ----------------------------------------------------------------
assign any_protection_trip = overvoltage_trip | overcurrent_trip
                           | overtemp_trip | sense_reversed;
assign fire_done = meas_settled & ~settled_prev_r;
assign fire_prot = any_protection_trip & ~prot_prev_r;

// line 1 trigger, only when automatic
assign trig_hit = (fn_of(func_r, 0) == `SLDIO_FN_AUTO) & (
                  ((edge_sel_r != `SLDIO_EDGE_RISE) & lvl1_prev_r & ~level[0]) |
                  ((edge_sel_r != `SLDIO_EDGE_FALL) & ~lvl1_prev_r & level[0]));

// ----------------------------------------------------------------
// pin drive
// ----------------------------------------------------------------
always @* begin
    out_nxt = {NLINES{1'b0}};
    oe_nxt  = {NLINES{1'b0}};
    for (i = 0; i < NLINES; i = i + 1) begin
        case (fn_of(func_r, i))
            `SLDIO_FN_OUT_HIGH: begin
                out_nxt[i] = 1'b1;
                oe_nxt[i]  = 1'b1;
            end
            `SLDIO_FN_OUT_LOW: begin
                out_nxt[i] = 1'b0;
                oe_nxt[i]  = 1'b1;
            end
            `SLDIO_FN_IN: begin
                oe_nxt[i] = 1'b0;
            end
            default: begin
                // automatic: only lines 2 and 3 drive
                if (i == 1) begin
                    out_nxt[i] = (done_cnt_r != {`SLDIO_CNT_W{1'b0}});
                    oe_nxt[i]  = 1'b1;
                end else if (i == 2) begin
                    out_nxt[i] = (prot_cnt_r != {`SLDIO_CNT_W{1'b0}});
                    oe_nxt[i]  = 1'b1;
                end else begin
                    oe_nxt[i] = 1'b0;
                end
            end
        endcase
    end
end

// ----------------------------------------------------------------
// readback request and events
// ----------------------------------------------------------------
always @* begin
    rddata_nxt = rddata_r;
    rd_err     = 1'b0;
    if (wr_acc && avs_address == `SLDIO_REG_RDREQ && avs_byteenable[0]) begin
        if (avs_writedata[2:0] < NLINES &&
            fn_of(func_r, avs_writedata[2:0]) == `SLDIO_FN_IN) begin
            rddata_nxt = {6'h00, 1'b1, level[avs_writedata[2:0]]};
        end else begin
            rddata_nxt = 8'h00;
            rd_err     = 1'b1;
        end
    end
    events = {`SLDIO_ST_W{1'b0}};
    events[`SLDIO_ST_TRIG] = trig_hit;
    events[`SLDIO_ST_ERR]  = rd_err;
    events[`SLDIO_ST_DONE] = fire_done;
    events[`SLDIO_ST_PROT] = fire_prot;
    status_nxt = status_r;
    if (wr_acc && avs_address == `SLDIO_REG_STATUS && avs_byteenable[0]) begin
        status_nxt = status_r & ~avs_writedata[`SLDIO_ST_W-1:0];
    end
    status_nxt = status_nxt | events; // set wins over clear
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
        `SLDIO_REG_FUNC:    rd_mux[2*NLINES-1:0] = func_r;
        `SLDIO_REG_EDGE:    rd_mux[1:0] = edge_sel_r;
        `SLDIO_REG_RDDATA:  rd_mux[7:0] = rddata_r;
        `SLDIO_REG_STATUS:  rd_mux[`SLDIO_ST_W-1:0] = status_r;
        `SLDIO_REG_MASK:    rd_mux[`SLDIO_ST_W-1:0] = mask_r;
        `SLDIO_REG_ERRCODE: rd_mux[15:0] = errcode_r;
        `SLDIO_REG_LEVELS:  rd_mux[NLINES-1:0] = level;
        default:            rd_mux = 32'h0000_0000;
    endcase
end

assign irq = |(status_r & mask_r);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
// bus handshake and read data
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        ack_r        <= 1'b0;
        avs_readdata <= 32'h0000_0000;
    end else begin
        ack_r <= (avs_read | avs_write) & ~ack_r;
        if (rd_load) begin
            // loaded in the wait cycle so it stands at the accept edge
            avs_readdata <= rd_mux;
        end
    end
end

// ----------------------------------------------------------------
// edge history
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        lvl1_prev_r    <= 1'b0;
        settled_prev_r <= 1'b0;
        prot_prev_r    <= 1'b0;
    end else begin
        lvl1_prev_r    <= level[0];
        settled_prev_r <= meas_settled;
        prot_prev_r    <= any_protection_trip;
    end
end

// ----------------------------------------------------------------
// line 2 pulse counter
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        done_cnt_r <= {`SLDIO_CNT_W{1'b0}};
    end else begin
        done_cnt_r <= cnt_step(fire_done, done_cnt_r, pulse_load);
    end
end

// ----------------------------------------------------------------
// line 3 pulse counter
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        prot_cnt_r <= {`SLDIO_CNT_W{1'b0}};
    end else begin
        prot_cnt_r <= cnt_step(fire_prot, prot_cnt_r, pulse_load);
    end
end

// ----------------------------------------------------------------
// line 1 trigger strobe
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        trigger_pulse_r <= 1'b0;
    end else begin
        trigger_pulse_r <= trig_hit;
    end
end

// ----------------------------------------------------------------
// pin drive registers
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        line_out_r <= {NLINES{1'b0}};
        line_oe_r  <= {NLINES{1'b0}};
    end else begin
        line_out_r <= out_nxt;
        line_oe_r  <= oe_nxt;
    end
end

// ----------------------------------------------------------------
// status, readback and error code
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        status_r  <= {`SLDIO_ST_W{1'b0}};
        rddata_r  <= 8'h00;
        errcode_r <= 16'h0000;
    end else begin
        status_r <= status_nxt;
        rddata_r <= rddata_nxt;
        if (rd_err) begin
            errcode_r <= `SLDIO_ERR_NOT_INPUT;
        end else if (wr_acc && avs_address == `SLDIO_REG_ERRCODE && avs_byteenable[0]) begin
            errcode_r <= 16'h0000;
        end
    end
end

// ----------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        func_r     <= `SLDIO_FN_RESET;
        edge_sel_r <= `SLDIO_EDGE_FALL;
        mask_r     <= {`SLDIO_ST_W{1'b0}};
    end else if (wr_acc) begin
        case (avs_address)
            `SLDIO_REG_FUNC: begin
                if (avs_byteenable[0]) begin
                    func_r[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    func_r[2*NLINES-1:8] <= avs_writedata[2*NLINES-1:8];
                end
            end
            `SLDIO_REG_EDGE: begin
                if (avs_byteenable[0]) begin
                    edge_sel_r <= avs_writedata[1:0];
                end
            end
            `SLDIO_REG_MASK: begin
                if (avs_byteenable[0]) begin
                    mask_r <= avs_writedata[`SLDIO_ST_W-1:0];
                end
            end
            default: begin
                mask_r <= mask_r;
            end
        endcase
    end
end

endmodule

/* File: rtl/sldio_consts.vh */
// constants for the six-line digital i/o port
// assumes a 100 mhz ref_clk and a 32-bit avalon-mm slave with waitrequest
`ifndef SLDIO_CONSTS_VH
`define SLDIO_CONSTS_VH

// ----------------------------------------------------------------
// line functions
// ----------------------------------------------------------------
`define SLDIO_FN_AUTO        2'h0
`define SLDIO_FN_OUT_HIGH    2'h1
`define SLDIO_FN_OUT_LOW     2'h2
`define SLDIO_FN_IN          2'h3
`define SLDIO_FN_RESET       12'hfc0

// ----------------------------------------------------------------
// edge sensitivity
// ----------------------------------------------------------------
`define SLDIO_EDGE_FALL      2'h0
`define SLDIO_EDGE_RISE      2'h1
`define SLDIO_EDGE_BOTH      2'h2

// ----------------------------------------------------------------
// register word offsets (byte address / 4)
// ----------------------------------------------------------------
`define SLDIO_REG_FUNC       4'h0
`define SLDIO_REG_EDGE       4'h1
`define SLDIO_REG_RDREQ      4'h2
`define SLDIO_REG_RDDATA     4'h3
`define SLDIO_REG_STATUS     4'h4
`define SLDIO_REG_MASK       4'h5
`define SLDIO_REG_ERRCODE    4'h6
`define SLDIO_REG_LEVELS     4'h7

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define SLDIO_ST_TRIG        0
`define SLDIO_ST_ERR         1
`define SLDIO_ST_DONE        2
`define SLDIO_ST_PROT        3
`define SLDIO_ST_W           4

// ----------------------------------------------------------------
// read data fields
// ----------------------------------------------------------------
`define SLDIO_RD_VALID       8
`define SLDIO_ERR_NOT_INPUT  16'h01fc

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SLDIO_CLK_MHZ        100
`define SLDIO_PULSE_US       10
`define SLDIO_PULSE_CYC      (`SLDIO_PULSE_US * `SLDIO_CLK_MHZ)
`define SLDIO_CNT_W          11

`endif

/* File: rtl/sldio_sync.v */
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/100ps
module sldio_sync #(
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input  wire ref_clk,
    input  wire reset,
    // pin and result
    input  wire pin_in,
    output reg  level_r
);

reg  s1_r;
reg  s2_r;
reg  s3_r;

// ----------------------------------------------------------------
// chain; the first stage feeds only the second
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (reset) begin
        s1_r    <= RST_VAL;
        s2_r    <= RST_VAL;
        s3_r    <= RST_VAL;
        level_r <= RST_VAL;
    end else begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
end

endmodule

/* File: test/sldio_monitor.sv */
// checker for the six-line port: bus timing, pin drive, pulses
// assumes binding to sldio_port, one clock, synchronous reset
`timescale 1ns/100ps
module sldio_monitor #(
    parameter NLINES = 6
) (
    // clock, reset and bus
    input wire              ref_clk,
    input wire              reset,
    input wire [3:0]        avs_address,
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_writedata,
    input wire [3:0]        avs_byteenable,
    input wire              avs_waitrequest,
    // events and lines
    input wire              meas_settled,
    input wire              overvoltage_trip,
    input wire              overcurrent_trip,
    input wire              overtemp_trip,
    input wire              sense_reversed,
    input wire              trigger_pulse_r,
    input wire [NLINES-1:0] line_out_r,
    input wire [NLINES-1:0] line_oe_r
);
    reg  [11:0] fn_r;
    reg  [10:0] hi_cnt_r;
    reg  [5:0]  hi_v, lo_v, in_v;
    wire        trip = overvoltage_trip | overcurrent_trip | overtemp_trip | sense_reversed;
    integer     i;
    // ----------------------------------------
    // function mirror from bus writes
    // ----------------------------------------
    always @* begin
        for (i = 0; i < 6; i = i + 1) begin
            hi_v[i] = fn_r[2*i+:2] == 2'h1;
            lo_v[i] = fn_r[2*i+:2] == 2'h2;
            in_v[i] = fn_r[2*i+:2] == 2'h3;
        end
    end
    always @(posedge ref_clk) begin
        hi_cnt_r <= (line_out_r[1] && !reset) ? hi_cnt_r + 11'h1 : 11'h0;
        if (reset) begin
            fn_r <= 12'hfc0;
        end else if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
            if (avs_byteenable[0]) fn_r[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) fn_r[11:8] <= avs_writedata[11:8];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence req_s; (avs_read || avs_write) && !$past(avs_read || avs_write); endsequence
    sequence done_s; $rose(meas_settled) && fn_r[3:2] == 2'h0; endsequence
    sequence prot_s; $rose(trip) && fn_r[5:4] == 2'h0; endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    wait_first_a: assert property (req_s |-> avs_waitrequest)
        else $error("no wait in first bus cycle");
    wait_end_a: assert property (req_s |=> !avs_waitrequest)
        else $error("bus access not done in two cycles");
    reset_dir_a: assert property ($fell(reset) |=> line_oe_r == 6'h06)
        else $error("bad pin directions after reset");
    done_rise_a: assert property (done_s |-> ##[1:2] line_out_r[1])
        else $error("no done pulse");
    done_width_a: assert property ($fell(line_out_r[1]) && fn_r[3:2] == 2'h0
        && $past(fn_r[3:2], 4) == 2'h0 |-> hi_cnt_r >= 11'h3e8) else $error("done pulse short");
    prot_rise_a: assert property (prot_s |-> ##[1:2] line_out_r[2])
        else $error("no protection pulse");
    hi_drive_a: assert property ((hi_v & $past(hi_v) & $past(hi_v, 2)
        & ~(line_oe_r & line_out_r)) == 6'h0) else $error("high line not driven high");
    lo_drive_a: assert property ((lo_v & $past(lo_v) & $past(lo_v, 2)
        & ~(line_oe_r & ~line_out_r)) == 6'h0) else $error("low line not driven low");
    in_free_a: assert property ((in_v & $past(in_v) & $past(in_v, 2)
        & line_oe_r) == 6'h0) else $error("input line driven");
    trig_one_a: assert property (trigger_pulse_r |=> !trigger_pulse_r)
        else $error("trigger longer than a cycle");
    trig_auto_a: assert property (trigger_pulse_r |-> $past(fn_r[1:0]) == 2'h0)
        else $error("trigger outside automatic function");
endmodule
bind sldio_port sldio_monitor #(.NLINES(NLINES)) u_sldio_monitor (.*);

/* File: test/sldio_equip.sv */
// external equipment on the six lines: drives released lines, times pulses
// assumes a pin shows the device level wherever its enable is high
`timescale 1ns/100ps
module sldio_equip (
    input  wire       ref_clk,
    input  wire [5:0] line_out_r,
    input  wire [5:0] line_oe_r,
    input  wire [5:0] drive,
    output wire [5:0] line_in,
    output integer    done_w,
    output integer    prot_w
);
    integer c2 = 0;
    integer c3 = 0;
    assign line_in = (line_oe_r & line_out_r) | (~line_oe_r & drive);
    always @(posedge ref_clk) begin
        c2 <= line_in[1] ? c2 + 1 : 0;
        c3 <= line_in[2] ? c3 + 1 : 0;
        if (!line_in[1] && c2 != 0) done_w <= c2;
        if (!line_in[2] && c3 != 0) prot_w <= c3;
    end
endmodule

/* File: test/six_line_digital_io_port_tb.sv */
// testbench for the six-line port with directed checks of its registers
// assumes sldio_port, sldio_equip and the bound checker
`timescale 1ns/100ps
`include "sldio_consts.vh"
module six_line_digital_io_port_tb;
    reg         ref_clk = 1'b0;
    reg         reset = 1'b1;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [4:0]  ev = 5'h0;
    reg  [5:0]  drive = 6'h0;
    reg  [31:0] rd;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, trigger_pulse_r, irq;
    wire [5:0]  line_in, line_out_r, line_oe_r;
    integer     done_w, prot_w, k, i, f, g;
    integer     failures = 0, comparisons = 0, trig_n = 0;
    integer     fn [0:5];
    sldio_port u_sldio_port (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .meas_settled(ev[0]), .overvoltage_trip(ev[1]), .overcurrent_trip(ev[2]),
        .overtemp_trip(ev[3]), .sense_reversed(ev[4]), .trigger_pulse_r(trigger_pulse_r),
        .line_in(line_in), .line_out_r(line_out_r), .line_oe_r(line_oe_r), .irq(irq));
    sldio_equip u_sldio_equip (.ref_clk(ref_clk), .line_out_r(line_out_r),
        .line_oe_r(line_oe_r), .drive(drive), .line_in(line_in), .done_w(done_w),
        .prot_w(prot_w));
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (trigger_pulse_r === 1'b1) trig_n <= trig_n + 1;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task bus(input wr, input [3:0] a, input [31:0] d);
        begin
            @(posedge ref_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            #1;
            while (avs_waitrequest !== 1'b0) begin
                @(posedge ref_clk);
                #1;
            end
            @(posedge ref_clk);
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task test_done;
        begin
            $display("comparisons=%0d failures=%0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        failures = failures + 1;
        test_done;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        k = $urandom(28);
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1 check(line_oe_r, 6'h06);
        bus(0, `SLDIO_REG_FUNC, 0);
        check(rd, 32'hfc0);
        bus(0, 4'hf, 0);
        check(rd, 0);
        for (k = 0; k < 4; k = k + 1) begin
            f = 0;
            for (i = 0; i < 6; i = i + 1) begin
                fn[i] = (i + k) % 4;
                f = f | (fn[i] << (2 * i));
            end
            bus(1, `SLDIO_REG_FUNC, f);
            bus(0, `SLDIO_REG_FUNC, 0);
            check(rd, f);
            drive <= 6'($urandom);
            repeat (8) @(posedge ref_clk);
            #1;
            for (i = 0; i < 6; i = i + 1) begin
                if (fn[i] == 1 || fn[i] == 2 || (fn[i] == 0 && (i == 1 || i == 2)))
                    check({line_oe_r[i], line_out_r[i]}, {1'b1, fn[i] == 1});
                if (fn[i] == 3 || (fn[i] == 0 && i != 1 && i != 2))
                    check(line_oe_r[i], 0);
                bus(1, `SLDIO_REG_RDREQ, i);
                bus(0, `SLDIO_REG_RDDATA, 0);
                check(rd, fn[i] == 3 ? 2 | drive[i] : 0);
                if (fn[i] != 3) begin
                    bus(0, `SLDIO_REG_ERRCODE, 0);
                    check(rd, 32'h1fc);
                    bus(0, `SLDIO_REG_STATUS, 0);
                    check(rd[1], 1);
                    bus(1, `SLDIO_REG_STATUS, 32'h2);
                    bus(1, `SLDIO_REG_ERRCODE, 0);
                end
            end
            bus(0, `SLDIO_REG_LEVELS, 0);
            g = 0;
            for (i = 0; i < 6; i = i + 1)
                g[i] = fn[i] == 1 || (fn[i] != 2 && drive[i]
                       && !(fn[i] == 0 && (i == 1 || i == 2)));
            check(rd, g);
        end
        bus(1, `SLDIO_REG_FUNC, 32'hfc0);
        drive <= 6'h0;
        for (k = 0; k < 3; k = k + 1) begin
            bus(1, `SLDIO_REG_EDGE, k);
            bus(1, `SLDIO_REG_MASK, k != 0);
            bus(1, `SLDIO_REG_STATUS, 32'hf);
            trig_n = 0;
            drive[0] <= 1'b1;
            repeat (8) @(posedge ref_clk);
            drive[0] <= 1'b0;
            repeat (8) @(posedge ref_clk);
            #1 check(trig_n, k == 2 ? 2 : 1);
            check(irq, k != 0);
            bus(1, `SLDIO_REG_STATUS, 32'h1);
            #1 check(irq, 0);
        end
        for (k = 0; k < 5; k = k + 1) begin
            g = 300 + $urandom % 400;
            @(posedge ref_clk);
            ev[k] <= 1'b1;
            @(posedge ref_clk);
            ev[k] <= 1'b0;
            repeat (g) @(posedge ref_clk);
            ev[k] <= k == 0;
            repeat (1600) @(posedge ref_clk);
            ev[k] <= 1'b0;
            #1;
            if (k == 0)
                check(done_w, g + 1001);
            else
                check(prot_w, 1000);
            bus(0, `SLDIO_REG_STATUS, 0);
            check(rd[3:2], k == 0 ? 1 : 2);
            bus(1, `SLDIO_REG_STATUS, 32'hc);
        end
        test_done;
    end
endmodule
